// >>> core/rcpm_top.v
// Pin-mode logic of a remote-control code transmitter/receiver
`timescale 1ns/1ps
`default_nettype none
`include "rcpm_map.vh"
module rcpm_top (
    input  wire                      clk_i,
    input  wire                      rst_n_i,
    input  wire [2:0]                mode_i,
    input  wire                      tx_data_i,
    input  wire                      tx_active_i,
    input  wire                      in_pin_i,
    output reg                       in_pin_o,
    output reg                       in_pin_oe_o,
    output reg                       out_pin_o,
    output reg                       out_pin_oe_o,
    input  wire                      timing_capacitor_hi_i,
    input  wire                      timing_capacitor_hv_i,
    input  wire                      timing_resistor_pin_i,
    input  wire [`RCPM_CODE_BITS-1:0] own_code_i,
    input  wire [1:0]                need_sel_i,
    input  wire                      window_open_i,
    output reg  [`RCPM_CODE_BITS-1:0] rx_code_o,
    output reg                       rx_code_valid_o,
    input  wire                      rx_code_ready_i,
    output reg                       commit_o,
    output reg  [`RCPM_CODE_BITS-1:0] commit_data_o,
    output reg                       test_mode_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [3:0] pins_s;
    wire       in_s;
    wire       cap_hi_s;
    wire       cap_hv_s;
    wire       res_s;

    // Every pin input arrives from outside the clock domain
    rcpm_sync #(.WIDTH(4)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({in_pin_i, timing_capacitor_hi_i, timing_capacitor_hv_i,
                   timing_resistor_pin_i}),
        .sync_o  (pins_s)
    );
    assign in_s     = pins_s[3];
    assign cap_hi_s = pins_s[2];
    assign cap_hv_s = pins_s[1];
    assign res_s    = pins_s[0];

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    reg  res_q;
    reg  hv_q;
    wire res_rise;
    wire res_fall;
    wire hv_rise;

    // Reset level matches the idle low level of both pins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_q <= 1'b0;
            hv_q  <= 1'b0;
        end else begin
            res_q <= res_s;
            hv_q  <= cap_hv_s;
        end
    end
    assign res_rise = res_s & ~res_q;
    assign res_fall = ~res_s & res_q;
    assign hv_rise  = cap_hv_s & ~hv_q;

    function need_met;
        input [1:0] sel;
        input [3:0] cnt;
        begin
            case (sel)
                `RCPM_NEED_SEL_2: need_met = (cnt >= `RCPM_GOOD_2);
                `RCPM_NEED_SEL_4: need_met = (cnt >= `RCPM_GOOD_4);
                default:          need_met = (cnt >= `RCPM_GOOD_8);
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Receive path and code FIFO
    // ------------------------------------------------------------
    wire                       is_rx;
    wire                       is_prog;
    wire                       is_xfer;
    reg  [`RCPM_CODE_BITS-1:0] rx_sh_q;
    reg  [2:0]                 rx_cnt_q;
    reg                        rx_push_q;
    wire                       fifo_in_ready;
    wire [`RCPM_CODE_BITS-1:0] fifo_data;
    wire                       fifo_valid;
    wire                       fifo_pop;

    assign is_rx   = (mode_i == `RCPM_MODE_RX_VALID) | (mode_i == `RCPM_MODE_RX_TOGGLE);
    assign is_prog = (mode_i == `RCPM_MODE_PROGRAM);
    assign is_xfer = is_prog | (mode_i == `RCPM_MODE_READ);
    assign fifo_pop = fifo_valid & (~rx_code_valid_o | rx_code_ready_i);

    // Sampling stalls while a finished word waits to enter the FIFO so no bit is overwritten
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_sh_q   <= 8'h00;
            rx_cnt_q  <= 3'h0;
            rx_push_q <= 1'b0;
        end else begin
            if (rx_push_q & fifo_in_ready) begin
                rx_push_q <= 1'b0;
            end
            if (!is_rx) begin
                rx_cnt_q <= 3'h0;
            end else if (res_rise & ~rx_push_q) begin
                rx_sh_q  <= {rx_sh_q[`RCPM_CODE_BITS-2:0], in_s};
                rx_cnt_q <= rx_cnt_q + 3'h1;
                if (rx_cnt_q == 3'h7) begin
                    rx_push_q <= 1'b1;
                end
            end
        end
    end

    rcpm_fifo #(
        .WIDTH (`RCPM_CODE_BITS),
        .DEPTH (`RCPM_FIFO_DEPTH),
        .AW    (`RCPM_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (rx_sh_q),
        .in_valid_i  (rx_push_q),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (~rx_code_valid_o | rx_code_ready_i)
    );

    // ------------------------------------------------------------
    // Valid-code qualification
    // ------------------------------------------------------------
    reg  [3:0] good_cnt_q;
    reg        valid_pulse_q;
    reg        toggle_q;
    wire       good_code;

    assign good_code = fifo_pop & (fifo_data == own_code_i);

    // Closing the window or leaving receive restarts the good-code count
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_code_o       <= 8'h00;
            rx_code_valid_o <= 1'b0;
            good_cnt_q      <= 4'h0;
            valid_pulse_q   <= 1'b0;
            toggle_q        <= 1'b0;
        end else begin
            if (fifo_pop) begin
                rx_code_o       <= fifo_data;
                rx_code_valid_o <= 1'b1;
            end else if (rx_code_ready_i) begin
                rx_code_valid_o <= 1'b0;
            end
            valid_pulse_q <= 1'b0;
            if (!window_open_i || !is_rx) begin
                good_cnt_q <= 4'h0;
            end else if (good_code) begin
                if (need_met(need_sel_i, good_cnt_q + 4'h1)) begin
                    good_cnt_q <= 4'h0;
                    if (mode_i == `RCPM_MODE_RX_VALID) begin
                        valid_pulse_q <= 1'b1;
                    end else begin
                        toggle_q <= ~toggle_q;
                    end
                end else begin
                    good_cnt_q <= good_cnt_q + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Program / read shifting and commit
    // ------------------------------------------------------------
    reg  [`RCPM_CODE_BITS-1:0] stored_q;
    reg  [`RCPM_CODE_BITS-1:0] prog_sh_q;
    reg  [`RCPM_CODE_BITS-1:0] out_sh_q;
    reg  [2:0]                 xfer_mode_q;

    // Serial output reloads from the stored word on every entry into program or read
    // Commit happens only on the rising edge of the high-voltage detect
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stored_q      <= `RCPM_STORED_RST;
            prog_sh_q     <= 8'h00;
            out_sh_q      <= `RCPM_STORED_RST;
            xfer_mode_q   <= 3'h0;
            commit_o      <= 1'b0;
            commit_data_o <= `RCPM_STORED_RST;
        end else begin
            xfer_mode_q <= mode_i;
            commit_o    <= 1'b0;
            if (is_xfer & (mode_i != xfer_mode_q)) begin
                out_sh_q <= stored_q;
            end else if (is_xfer & res_rise) begin
                out_sh_q <= {out_sh_q[`RCPM_CODE_BITS-2:0], 1'b0};
                if (is_prog & cap_hi_s) begin
                    prog_sh_q <= {prog_sh_q[`RCPM_CODE_BITS-2:0], in_s};
                end
            end
            if (is_prog & hv_rise) begin
                stored_q      <= prog_sh_q;
                commit_o      <= 1'b1;
                commit_data_o <= prog_sh_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Test-mode entry
    // ------------------------------------------------------------
    reg [1:0] low_cnt_q;

    // Counting restarts whenever the capacitor pin drops or a transfer mode runs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_q   <= 2'h0;
            test_mode_o <= 1'b0;
        end else if (!cap_hi_s || is_xfer) begin
            low_cnt_q   <= 2'h0;
            test_mode_o <= 1'b0;
        end else if (res_fall) begin
            if (low_cnt_q == `RCPM_TEST_PULSES - 2'h1) begin
                test_mode_o <= 1'b1;
            end else begin
                low_cnt_q <= low_cnt_q + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_pin_o     <= 1'b0;
            in_pin_oe_o  <= 1'b0;
            out_pin_o    <= 1'b0;
            out_pin_oe_o <= 1'b0;
        end else begin
            in_pin_o     <= 1'b0;
            in_pin_oe_o  <= 1'b0;
            out_pin_o    <= 1'b0;
            out_pin_oe_o <= 1'b0;
            case (mode_i)
                `RCPM_MODE_TX: begin
                    in_pin_oe_o  <= 1'b1;
                    in_pin_o     <= tx_active_i & tx_data_i;
                    out_pin_oe_o <= tx_active_i;
                    out_pin_o    <= ~tx_data_i;
                end
                `RCPM_MODE_RX_VALID: begin
                    out_pin_oe_o <= 1'b1;
                    out_pin_o    <= valid_pulse_q;
                end
                `RCPM_MODE_RX_TOGGLE: begin
                    out_pin_oe_o <= 1'b1;
                    out_pin_o    <= toggle_q;
                end
                `RCPM_MODE_PROGRAM,
                `RCPM_MODE_READ: begin
                    out_pin_oe_o <= 1'b1;
                    out_pin_o    <= out_sh_q[`RCPM_CODE_BITS-1];
                end
                default: begin
                    // Unused modes release both pins
                    out_pin_oe_o <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> core/rcpm_map.vh
// Constants of the remote-code pin-mode logic
`ifndef RCPM_MAP_VH
`define RCPM_MAP_VH
// Mode codes on mode_i
`define RCPM_MODE_TX        3'h0
`define RCPM_MODE_RX_VALID  3'h1
`define RCPM_MODE_RX_TOGGLE 3'h2
`define RCPM_MODE_PROGRAM   3'h3
`define RCPM_MODE_READ      3'h4
// Code and memory geometry
`define RCPM_CODE_BITS      8
`define RCPM_FIFO_DEPTH     16
`define RCPM_FIFO_AW        4
// Valid-code count selection codes
`define RCPM_NEED_SEL_2     2'h0
`define RCPM_NEED_SEL_4     2'h1
`define RCPM_NEED_SEL_8     2'h2
// Good-code counts that release a valid pulse or a toggle
`define RCPM_GOOD_2         4'h2
`define RCPM_GOOD_4         4'h4
`define RCPM_GOOD_8         4'h8
// Test-mode entry: low pulses on the timing resistor pin
`define RCPM_TEST_PULSES    2'h3
// Reset values
`define RCPM_STORED_RST     8'h00
`endif

// >>> core/rcpm_fifo.v
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rcpm_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop & !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// >>> core/rcpm_sync.v
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module rcpm_sync #(
    parameter WIDTH = 4
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> test/rcpm_chk.sv
// Assertions on the ports of the remote-code pin-mode logic
`timescale 1ns/1ps
`default_nettype none
`include "rcpm_map.vh"
module rcpm_chk (
    input wire logic                       clk_i,
    input wire logic                       rst_n_i,
    input wire logic [2:0]                 mode_i,
    input wire logic                       tx_data_i,
    input wire logic                       tx_active_i,
    input wire logic                       timing_capacitor_hi_i,
    input wire logic                       timing_capacitor_hv_i,
    input wire logic [`RCPM_CODE_BITS-1:0] own_code_i,
    input wire logic                       rx_code_ready_i,
    input wire logic                       in_pin_o,
    input wire logic                       out_pin_o,
    input wire logic                       out_pin_oe_o,
    input wire logic [`RCPM_CODE_BITS-1:0] rx_code_o,
    input wire logic                       rx_code_valid_o,
    input wire logic                       commit_o,
    input wire logic                       test_mode_o
);
    logic [1:0] live_q;
    logic       prev_take_q;
    // A good code is a matching word freshly loaded into the output register
    wire        good = rx_code_valid_o && prev_take_q && rx_code_o == own_code_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // live_q[1] sets two edges after reset release, so the transmit checks only use valid $past values
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_q      <= 2'h0;
            prev_take_q <= 1'b1;
        end else begin
            live_q      <= {live_q[0], 1'b1};
            prev_take_q <= !rx_code_valid_o || rx_code_ready_i;
        end
    end
    AST_TX_COPY: assert property (
        live_q[1] && $past(mode_i) == `RCPM_MODE_TX && $past(tx_active_i) |->
        in_pin_o == $past(tx_data_i) && out_pin_o != $past(tx_data_i) && out_pin_oe_o)
        else $error("transmit pins do not follow the data bit");
    AST_TX_STBY: assert property (
        live_q[1] && $past(mode_i) == `RCPM_MODE_TX && !$past(tx_active_i) |->
        !in_pin_o && !out_pin_oe_o)
        else $error("transmit standby pins not cleared");
    AST_VPULSE: assert property (
        mode_i == `RCPM_MODE_RX_VALID && $past(mode_i) == `RCPM_MODE_RX_VALID
        && $rose(out_pin_o) |-> $past(good) ##1 !out_pin_o)
        else $error("valid pulse without a good code or too long");
    AST_TOGGLE: assert property (
        $past(mode_i) == `RCPM_MODE_RX_TOGGLE && $past(mode_i, 2) == `RCPM_MODE_RX_TOGGLE
        && $changed(out_pin_o) |-> $past(good))
        else $error("toggle output changed without a good code");
    AST_RX_HOLD: assert property (
        rx_code_valid_o && !rx_code_ready_i |=> rx_code_valid_o && $stable(rx_code_o))
        else $error("received code dropped before it was taken");
    AST_COMMIT: assert property (
        commit_o |-> $past(mode_i) == `RCPM_MODE_PROGRAM && $past(timing_capacitor_hv_i)
        ##1 !commit_o)
        else $error("commit pulse without a programming pulse");
    AST_TEST_ON: assert property (
        $rose(test_mode_o) |-> $past(timing_capacitor_hi_i, 3)
        && $past(mode_i) != `RCPM_MODE_PROGRAM && $past(mode_i) != `RCPM_MODE_READ)
        else $error("test mode entered without the capacitor pin high");
    AST_TEST_OFF: assert property (
        !timing_capacitor_hi_i [*4] |-> !test_mode_o)
        else $error("test mode kept after the capacitor pin dropped");
endmodule
bind rcpm_top rcpm_chk u_chk (
    .clk_i, .rst_n_i, .mode_i, .tx_data_i, .tx_active_i, .timing_capacitor_hi_i,
    .timing_capacitor_hv_i, .own_code_i, .rx_code_ready_i, .in_pin_o, .out_pin_o,
    .out_pin_oe_o, .rx_code_o, .rx_code_valid_o, .commit_o, .test_mode_o
);
`default_nettype wire

// >>> test/rcpm_far_model.sv
// Far-side model: remote link sender or programmer on the pins
`timescale 1ns/1ps
`default_nettype none
module rcpm_far_model (
    input  wire logic clk_i,
    input  wire logic out_level_i,
    output var  logic data_o,
    output var  logic sclk_o
);
    initial begin
        data_o = 1'b0;
        sclk_o = 1'b0;
    end
    // MSB first, one bit per shift clock; output pin read before each rise
    task automatic shift(input logic [7:0] d, input int half, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            got[i] = out_level_i;
            data_o = d[i];
            repeat (half) @(posedge clk_i);
            #1 sclk_o = 1'b1;
            repeat (half) @(posedge clk_i);
            #1 sclk_o = 1'b0;
        end
        data_o = ~d[0];
    endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking testbench of the remote-code pin-mode logic
`timescale 1ns/1ps
`default_nettype none
`include "rcpm_map.vh"
module testbench;
    logic       clk_i, rst_n_i, tx_data_i, tx_active_i, rx_code_ready_i, window_open_i;
    logic       timing_capacitor_hi_i, timing_capacitor_hv_i, res_hi;
    logic [2:0] mode_i;
    logic [1:0] need_sel_i;
    logic [7:0] own_code_i, rx_code_o, commit_data_o, exp_code, step, got;
    logic       in_pin_o, in_pin_oe_o, out_pin_o, out_pin_oe_o, rx_code_valid_o;
    logic       commit_o, test_mode_o, far_data, far_sclk, lvl;
    int         errors, cmp_count, pops, pulses;
    wire        in_pin_i = in_pin_oe_o ? in_pin_o : far_data;
    wire        out_level = out_pin_oe_o ? out_pin_o : 1'b1;
    wire        timing_resistor_pin_i = far_sclk | res_hi;
    rcpm_top u_dut (
        .clk_i, .rst_n_i, .mode_i, .tx_data_i, .tx_active_i, .in_pin_i, .in_pin_o,
        .in_pin_oe_o, .out_pin_o, .out_pin_oe_o, .timing_capacitor_hi_i,
        .timing_capacitor_hv_i, .timing_resistor_pin_i, .own_code_i, .need_sel_i,
        .window_open_i, .rx_code_o, .rx_code_valid_o, .rx_code_ready_i, .commit_o,
        .commit_data_o, .test_mode_o
    );
    rcpm_far_model u_far (.clk_i, .out_level_i(out_level), .data_o(far_data), .sclk_o(far_sclk));
    always #5 clk_i = ~clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic finish_test;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        if (rx_code_valid_o && rx_code_ready_i) begin
            check(rx_code_o, exp_code);
            exp_code <= exp_code + step;
            pops <= pops + 1;
        end
        if (mode_i == `RCPM_MODE_RX_VALID && out_pin_o)
            pulses <= pulses + 1;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_tx;
        mode_i = `RCPM_MODE_TX;
        tx_active_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            tx_data_i = i[0] ^ i[1];
            cyc(1);
            check(8'(in_pin_o), 8'(tx_data_i));
            check(8'(out_pin_o), 8'(!tx_data_i));
            check(8'(out_pin_oe_o), 8'h1);
            check(8'(in_pin_oe_o), 8'h1);
        end
        tx_active_i = 1'b0;
        cyc(1);
        check(8'(in_pin_o), 8'h0);
        check(8'(out_pin_oe_o), 8'h0);
    endtask
    task automatic open_window;
        window_open_i = 1'b0;
        cyc(2);
        window_open_i = 1'b1;
    endtask
    task automatic send_good(input int n);
        for (int k = 0; k < n; k++) begin
            u_far.shift(own_code_i, 6, got);
            cyc(30);
        end
    endtask
    task automatic test_rx_valid;
        mode_i = `RCPM_MODE_RX_VALID;
        own_code_i = 8'h5a;
        exp_code = 8'h5a;
        for (int s = 0; s < 3; s++) begin
            need_sel_i = s[1:0];
            open_window();
            pulses = 0;
            send_good((2 << s) - 1);
            check(8'(pulses), 8'h0);
            send_good(1);
            check(8'(pulses), 8'h1);
            check(8'(out_pin_o), 8'h0);
            check(8'(out_pin_oe_o), 8'h1);
        end
    endtask
    task automatic test_toggle;
        mode_i = `RCPM_MODE_RX_TOGGLE;
        need_sel_i = `RCPM_NEED_SEL_2;
        open_window();
        cyc(4);
        lvl = out_pin_o;
        send_good(2);
        check(8'(out_pin_o), 8'(!lvl));
        send_good(2);
        check(8'(out_pin_o), 8'(lvl));
    endtask
    task automatic test_fifo;
        own_code_i = 8'hff;
        rx_code_ready_i = 1'b0;
        exp_code = 8'h00;
        step = 8'h01;
        pops = 0;
        for (int i = 0; i < 20; i++)
            u_far.shift(8'(i), 6, got);
        cyc(10);
        rx_code_ready_i = 1'b1;
        cyc(40);
        check(8'(pops >= 16 && pops < 20), 8'h1);
        check(8'(rx_code_valid_o), 8'h0);
        step = 8'h00;
    endtask
    task automatic test_prog;
        mode_i = 3'h7;
        cyc(2);
        timing_capacitor_hi_i = 1'b1;
        mode_i = `RCPM_MODE_PROGRAM;
        cyc(8);
        u_far.shift(8'ha5, 6, got);
        check(got, `RCPM_STORED_RST);
        timing_capacitor_hv_i = 1'b1;
        for (int n = 0; n < 20 && !commit_o; n++)
            cyc(1);
        check(8'(commit_o), 8'h1);
        check(commit_data_o, 8'ha5);
        cyc(1);
        check(8'(commit_o), 8'h0);
        timing_capacitor_hv_i = 1'b0;
        mode_i = 3'h7;
        cyc(2);
        mode_i = `RCPM_MODE_PROGRAM;
        cyc(8);
        u_far.shift(8'h3c, 11, got);
        check(got, 8'ha5);
        timing_capacitor_hi_i = 1'b0;
        mode_i = `RCPM_MODE_READ;
        cyc(8);
        u_far.shift(8'h00, 6, got);
        check(got, 8'ha5);
    endtask
    task automatic test_testmode;
        mode_i = 3'h7;
        res_hi = 1'b1;
        timing_capacitor_hi_i = 1'b1;
        cyc(8);
        for (int p = 0; p < 3; p++) begin
            check(8'(test_mode_o), 8'h0);
            res_hi = 1'b0;
            cyc(5);
            res_hi = 1'b1;
            cyc(5);
        end
        check(8'(test_mode_o), 8'h1);
        timing_capacitor_hi_i = 1'b0;
        cyc(6);
        check(8'(test_mode_o), 8'h0);
    endtask
    initial begin
        {clk_i, rst_n_i, tx_data_i, tx_active_i, window_open_i, res_hi} = 6'h00;
        {timing_capacitor_hi_i, timing_capacitor_hv_i, need_sel_i} = 4'h0;
        {mode_i, own_code_i, exp_code, step} = {3'h7, 24'h0};
        {errors, cmp_count, pops, pulses} = '0;
        rx_code_ready_i = 1'b1;
        repeat (16) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        cyc(4);
        test_tx();
        test_rx_valid();
        test_toggle();
        test_fifo();
        test_prog();
        test_testmode();
        finish_test();
    end
    initial begin
        #300000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
